/* sim/scke_mc_model.sv */
`default_nettype none
// Controller side: drives clock enable and the command lines.
module scke_mc_model
#(
	parameter int TXS = 8
)
(
	input wire logic core_clk, // Clock.
	input wire logic cke_req, // Wanted enable.
	input wire logic [3:0] cmd_req, // Wanted command.
	input wire logic bad_exit, // Spoil exits.
	output logic cke, // Enable.
	output logic [3:0] cmd // Select, row, column, write.
);
	timeunit 1ns;
	timeprecision 1ns;
	int hold = 0;
	initial cke = 1'b0;
	initial cmd = 4'h7;
	// Exits carry no-operation unless bad_exit is set, then stay quiet; low cycles float.
	always @(posedge core_clk)
	begin
		cke <= cke_req;
		if (cke_req && !cke)
		begin
			hold <= TXS;
			cmd <= bad_exit ? 4'h0 : 4'h7;
		end
		else if (hold > 0)
		begin
			hold <= hold - 1;
			cmd <= 4'h7;
		end
		else
			cmd <= cke_req || cke ? cmd_req : ~cmd;
	end
endmodule : scke_mc_model
`default_nettype wire

/* sim/scke_power_ctrl_assertions.sv */
`default_nettype none
// Ties the power-state flags to clock enable and command.
module scke_power_ctrl_assertions
	import scke_pkg::*;
#(
	parameter int CW = 16
)
(
	input wire logic core_clk, // Clock.
	input wire logic resetn, // Reset.
	input wire logic cke, // Enable.
	input wire logic cs_n, // Select.
	input wire logic ras_n, // Row.
	input wire logic cas_n, // Column.
	input wire logic we_n, // Write.
	input wire logic [CW-1:0] t_xsdll, // Delay.
	input wire logic [2:0] power_state, // State.
	input wire logic in_power_down, // Down.
	input wire logic in_self_refresh, // Self.
	input wire logic read_allowed, // Reads.
	input wire logic write_allowed, // Writes.
	input wire logic illegal_seq // Fault.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Deselect acts as no-operation.
	wire nop = cs_n || (ras_n && cas_n && we_n);
	logic [10:0] srx_r;
	// Cycles since exit; saturates so an idle spell never wraps back.
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn) srx_r <= 11'h7FF;
		else if (in_self_refresh) srx_r <= 11'h000;
		else if (srx_r != 11'h7FF) srx_r <= srx_r + 11'h001;
	sequence s_fall;
		$fell(cke) && nop;
	endsequence
	a_pd_hold: assert property (in_power_down && !cke |=> in_power_down) else $error("pd lost");
	a_sr_hold: assert property (in_self_refresh && !cke |=> in_self_refresh) else $error("sr lost");
	a_sr_idle: assert property ($rose(in_self_refresh) |-> $past(power_state) == SCKE_IDLE) else $error("sr");
	a_apd_entry: assert property (s_fall ##0 power_state == SCKE_ACTIVE |=> power_state == SCKE_APD)
		else $error("no apd");
	a_ppd_entry: assert property (s_fall ##0 power_state inside {SCKE_IDLE, SCKE_REFRESHING}
		|=> power_state == SCKE_PPD) else $error("no ppd");
	a_pd_exit: assert property (in_power_down && $rose(cke) |=> !in_power_down) else $error("pd exit");
	a_sr_exit: assert property (in_self_refresh && cke |=> !in_self_refresh) else $error("sr exit");
	a_cmd_ignore: assert property ((in_power_down || in_self_refresh) && !cke |=> $stable(illegal_seq))
		else $error("cmd seen");
	a_bad_exit: assert property (in_power_down && $rose(cke) && !nop |=> illegal_seq) else $error("bad");
	a_write_wait: assert property (write_allowed |-> srx_r >= 11'h200) else $error("early write");
	a_read_wait: assert property (read_allowed |-> srx_r >= 11'(t_xsdll)) else $error("early rd");
endmodule : scke_power_ctrl_assertions
bind scke_power_ctrl scke_power_ctrl_assertions #(.CW(CW)) chk (.core_clk, .resetn, .cke, .cs_n, .ras_n,
	.cas_n, .we_n, .t_xsdll, .power_state, .in_power_down, .in_self_refresh, .read_allowed, .write_allowed,
	.illegal_seq);
`default_nettype wire

/* sim/tb_top.sv */
`default_nettype none
// Walks the block through power-down, self refresh and a bad exit.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import scke_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic cke_req = 1'b1;
	logic [3:0] cmd_req = 4'h7;
	logic bad_exit = 1'b0;
	logic banks_open = 1'b0;
	logic burst_busy = 1'b0;
	logic cke;
	logic [3:0] cmd;
	logic [2:0] power_state;
	logic in_power_down, in_self_refresh, cmd_accept, device_idle, read_allowed, write_allowed, illegal_seq;
	int bad_count = 0;
	int checks_done = 0;
	scke_mc_model #(.TXS(8)) ctrl (.core_clk, .cke_req, .cmd_req, .bad_exit, .cke, .cmd);
	scke_power_ctrl uut (.core_clk, .resetn, .cke, .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]),
		.we_n(cmd[0]), .a10(1'b0), .banks_open, .burst_busy, .t_xs(16'h0008), .t_xsdll(16'h0010),
		.t_op(16'h0004), .power_state, .in_power_down, .in_self_refresh, .cmd_accept, .device_idle,
		.read_allowed, .write_allowed, .illegal_seq);
	// Free-running clock.
	initial forever #10 core_clk = ~core_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	task automatic drive(input logic k, input logic [3:0] c);
		@(posedge core_clk);
		cke_req <= k;
		cmd_req <= c;
	endtask : drive
	// Bounded wait: 0 state, 1 idle, 2 reads, 3 writes.
	task automatic wait_on(input int w, input logic [2:0] s, output int n);
		n = 0;
		while (!(w == 0 ? power_state === s : w == 1 ? device_idle === 1'b1 : w == 2 ? read_allowed === 1'b1
			: write_allowed === 1'b1))
		begin
			@(negedge core_clk);
			n++;
			if (n > 2000)
			begin
				bad_count++;
				$display("mismatch at %0t: wait timed out", $time);
				test_done();
			end
		end
	endtask : wait_on
	task automatic t_pd(input logic act);
		int n;
		// Let the model's quiet spell after an exit run out, or it swallows the activate.
		repeat (10) @(posedge core_clk);
		banks_open <= act;
		if (act)
		begin
			drive(1'b1, 4'h3);
			drive(1'b1, 4'h7);
		end
		wait_on(0, act ? SCKE_ACTIVE : SCKE_IDLE, n);
		drive(1'b0, 4'h7);
		wait_on(0, act ? SCKE_APD : SCKE_PPD, n);
		chk(n <= 4, 1'b1);
		repeat (12) @(negedge core_clk);
		chk(in_power_down, 1'b1);
		chk(cmd_accept, 1'b0);
		chk(illegal_seq, 1'b0);
		drive(1'b1, 4'h7);
		wait_on(0, act ? SCKE_ACTIVE : SCKE_IDLE, n);
		chk(n <= 4, 1'b1);
		if (act)
		begin
			// Precharge the bank so the later scenarios start from idle.
			repeat (10) @(posedge core_clk);
			banks_open <= 1'b0;
			drive(1'b1, 4'h2);
			drive(1'b1, 4'h7);
			wait_on(0, SCKE_IDLE, n);
			chk(n <= 10, 1'b1);
		end
		$display("power-down test done");
	endtask : t_pd
	// A read still bursting when CKE falls; banks are closed by then, so precharge power-down.
	task automatic t_busy;
		int n;
		@(posedge core_clk);
		banks_open <= 1'b1;
		drive(1'b1, 4'h3);
		drive(1'b1, 4'h5);
		burst_busy <= 1'b1;
		drive(1'b1, 4'h7);
		wait_on(0, SCKE_BUSY, n);
		chk(n <= 4, 1'b1);
		chk(cmd_accept, 1'b1);
		chk(device_idle, 1'b0);
		@(posedge core_clk);
		banks_open <= 1'b0;
		drive(1'b0, 4'h7);
		wait_on(0, SCKE_PPD, n);
		chk(in_power_down, 1'b1);
		repeat (6) @(negedge core_clk);
		drive(1'b1, 4'h7);
		burst_busy <= 1'b0;
		wait_on(0, SCKE_IDLE, n);
		chk(illegal_seq, 1'b0);
		$display("busy power-down test done");
	endtask : t_busy
	task automatic t_sr;
		int n;
		int m;
		// The model forces no-operation for a while after any exit; the refresh must not fall into it.
		repeat (10) @(posedge core_clk);
		wait_on(1, SCKE_IDLE, n);
		drive(1'b0, 4'h1);
		drive(1'b0, 4'h7);
		wait_on(0, SCKE_SELF_REF, n);
		chk(in_self_refresh, 1'b1);
		repeat (20) @(negedge core_clk);
		chk(power_state, SCKE_SELF_REF);
		chk(illegal_seq, 1'b0);
		drive(1'b1, 4'h7);
		wait_on(0, SCKE_IDLE, n);
		chk(read_allowed, 1'b0);
		wait_on(2, SCKE_IDLE, n);
		chk(n >= 13 && n <= 20, 1'b1);
		wait_on(3, SCKE_IDLE, m);
		chk(n + m >= 508 && n + m <= 516, 1'b1);
		$display("self-refresh test done");
	endtask : t_sr
	task automatic t_bad;
		int n;
		drive(1'b0, 4'h7);
		wait_on(0, SCKE_PPD, n);
		repeat (6) @(negedge core_clk);
		drive(1'b1, 4'h7);
		bad_exit <= 1'b1;
		wait_on(0, SCKE_IDLE, n);
		chk(illegal_seq, 1'b1);
		$display("bad exit test done");
	endtask : t_bad
	// Reset, then each scenario in turn.
	initial
	begin
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (10) @(negedge core_clk);
		chk(power_state, SCKE_IDLE);
		chk(illegal_seq, 1'b0);
		t_pd(1'b0);
		t_pd(1'b1);
		t_busy();
		t_sr();
		t_bad();
		test_done();
	end
endmodule : tb_top
`default_nettype wire

/* src/scke_defines.svh */
// Function
// - CKE sampled each edge against previous edge.
// - Power-down holds; no internal refresh.
// - Self refresh holds whatever the commands.
// - Self refresh entered only from idle.
// - Banks active plus CKE fall: active power-down.
// - Power-down after burst depends on open banks.
// - Refreshing or idle plus CKE fall: precharge power-down.
// - Idle needs closed banks, no burst, timings met.
// - Commands ignored in low-power states.
// - Unlisted combinations are illegal.
// - Self-refresh exit recognised asynchronously; here taken on the CKE level at the clock edge.
// - Deselect equals NOP; bursts not ended.
`ifndef SCKE_DEFINES_SVH
`define SCKE_DEFINES_SVH
`define SCKE_WRITE_AFTER_SRX 16'h0200
`define SCKE_CNT_W 16
`define SCKE_CMD_W 4
`endif

/* src/scke_pkg.sv */
`default_nettype none
package scke_pkg;
	// Power states of the device; binary codes written out.
	typedef enum logic [2:0]
	{
		SCKE_IDLE = 3'b000,
		SCKE_ACTIVE = 3'b001,
		SCKE_BUSY = 3'b010,
		SCKE_REFRESHING = 3'b011,
		SCKE_PPD = 3'b100,
		SCKE_APD = 3'b101,
		SCKE_SELF_REF = 3'b110
	} scke_state_e;
endpackage : scke_pkg
`default_nettype wire

/* src/scke_power_ctrl.sv */
`include "scke_defines.svh"
`default_nettype none
// CKE-driven power state tracking of the memory device.
module scke_power_ctrl
	import scke_pkg::*;
#(
	parameter int CW = `SCKE_CNT_W
)
(
	input wire logic core_clk, // Device clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic cke, // Clock enable, sampled each edge.
	input wire logic cs_n, // Chip select, active low.
	input wire logic ras_n, // Row strobe, active low.
	input wire logic cas_n, // Column strobe, active low.
	input wire logic we_n, // Write enable, active low.
	input wire logic a10, // Auto precharge / all-bank bit.
	input wire logic banks_open, // At least one bank is open.
	input wire logic burst_busy, // A read or write burst is running.
	input wire logic [CW-1:0] t_xs, // Self-refresh exit delay.
	input wire logic [CW-1:0] t_xsdll, // DLL-locked exit delay.
	input wire logic [CW-1:0] t_op, // Delay of prior operations.
	output logic [2:0] power_state, // Current state code.
	output logic in_power_down, // Power-down in effect.
	output logic in_self_refresh, // Self refresh in effect.
	output logic cmd_accept, // Command inputs are being decoded.
	output logic device_idle, // Idle as defined for power entry.
	output logic read_allowed, // Reads and termination allowed.
	output logic write_allowed, // Writes and leveling allowed.
	output logic illegal_seq // Sticky: an unlisted combination was seen.
);
	logic rst_m_r;
	logic rst_n_r;
	logic cke_prev_r;
	scke_state_e state_r;
	scke_state_e state_nxt;
	logic illegal_nxt;
	logic [CW-1:0] wr_cnt_r;
	logic xs_done;
	logic xsdll_done;
	logic op_done;

	// Reset is released through two flops so all logic leaves reset together.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_m_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_m_r <= 1'b1;
			rst_n_r <= rst_m_r;
		end
	end

	// Command decode; deselect is treated exactly as a NOP.
	wire cmd_nop = cs_n | (ras_n & cas_n & we_n);
	wire cmd_ref = !cs_n & !ras_n & !cas_n & we_n;
	wire cmd_rd = !cs_n & ras_n & !cas_n & we_n;
	wire cmd_wr = !cs_n & ras_n & !cas_n & !we_n;
	wire cmd_act = !cs_n & !ras_n & cas_n & we_n;
	wire cmd_pre = !cs_n & !ras_n & cas_n & !we_n;
	wire cmd_mrs = !cs_n & !ras_n & !cas_n & !we_n;
	wire cmd_zq = !cs_n & ras_n & cas_n & !we_n;
	wire cke_fall = cke_prev_r & !cke;
	wire cke_rise = !cke_prev_r & cke;
	wire cke_high = cke_prev_r & cke;
	wire low_power = (state_r == SCKE_PPD) || (state_r == SCKE_APD) || (state_r == SCKE_SELF_REF);
	wire timed_load = cmd_mrs | cmd_zq | cmd_ref | cmd_pre;
	// Idle needs closed banks, no burst, high CKE and the operation and self-refresh exit delays expired.
	wire idle_now = !banks_open & !burst_busy & cke_prev_r & op_done & xs_done;
	wire srx_event = (state_r == SCKE_SELF_REF) & cke_rise;
	wire write_ok = (wr_cnt_r == '0);

	// Timer of earlier operations, loaded by any command with a recovery time.
	scke_timer #(.W(CW)) u_op_timer
	(
		.core_clk(core_clk),
		.rst_n(rst_n_r),
		.load(cke_high & timed_load),
		.count(t_op),
		.done(op_done)
	);

	// Self-refresh exit delay; only deselect or NOP are expected meanwhile.
	scke_timer #(.W(CW)) u_xs_timer
	(
		.core_clk(core_clk),
		.rst_n(rst_n_r),
		.load(srx_event),
		.count(t_xs),
		.done(xs_done)
	);

	// DLL lock delay after self-refresh exit gates reads and termination.
	scke_timer #(.W(CW)) u_xsdll_timer
	(
		.core_clk(core_clk),
		.rst_n(rst_n_r),
		.load(srx_event),
		.count(t_xsdll),
		.done(xsdll_done)
	);

	// Next state, keyed on the state before the edge and the two CKE samples.
	always_comb
	begin
		state_nxt = state_r;
		illegal_nxt = 1'b0;
		unique case (state_r)
			SCKE_PPD, SCKE_APD:
			begin
				// Held low: stay put, no refresh, commands ignored.
				if (cke_rise)
				begin
					state_nxt = banks_open ? SCKE_ACTIVE : SCKE_IDLE;
					illegal_nxt = !cmd_nop;
				end
				else
				begin
					state_nxt = state_r;
				end
			end
			SCKE_SELF_REF:
			begin
				// Exit is taken on the level, not on the command.
				if (cke)
				begin
					state_nxt = SCKE_IDLE;
					illegal_nxt = !cmd_nop;
				end
				else
				begin
					state_nxt = SCKE_SELF_REF;
				end
			end
			SCKE_IDLE:
			begin
				if (cke_fall && cmd_ref && idle_now)
					state_nxt = SCKE_SELF_REF;
				else if (cke_fall && cmd_nop)
					state_nxt = SCKE_PPD;
				else if (cke_fall)
					illegal_nxt = 1'b1;
				else if (cke_high && cmd_ref)
					state_nxt = SCKE_REFRESHING;
				else if (cke_high && cmd_act)
					state_nxt = SCKE_ACTIVE;
				// The first rise after reset lands here and is harmless; only CKE held low is unlisted.
				else if (!cke_prev_r && !cke)
					illegal_nxt = 1'b1;
			end
			SCKE_ACTIVE:
			begin
				if (cke_fall && cmd_nop)
					state_nxt = SCKE_APD;
				else if (cke_fall)
					illegal_nxt = 1'b1;
				else if (cke_high && (cmd_rd || cmd_wr || cmd_pre))
					state_nxt = SCKE_BUSY;
				else if (!cke_prev_r && !cke)
					illegal_nxt = 1'b1;
			end
			SCKE_BUSY:
			begin
				// Power-down type depends on the banks open at the edge where CKE falls.
				if (cke_fall && cmd_nop)
					state_nxt = banks_open ? SCKE_APD : SCKE_PPD;
				else if (cke_fall)
					illegal_nxt = 1'b1;
				else if (!burst_busy && op_done)
					state_nxt = banks_open ? SCKE_ACTIVE : SCKE_IDLE;
			end
			SCKE_REFRESHING:
			begin
				if (cke_fall && cmd_nop)
					state_nxt = SCKE_PPD;
				else if (cke_fall)
					illegal_nxt = 1'b1;
				else if (op_done)
					state_nxt = SCKE_IDLE;
			end
			default:
			begin
				state_nxt = SCKE_IDLE;
				illegal_nxt = 1'b1;
			end
		endcase
	end

	// State, CKE history and the sticky illegal flag.
	always_ff @(posedge core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			state_r <= SCKE_IDLE;
			cke_prev_r <= 1'b0;
			illegal_seq <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cke_prev_r <= cke;
			illegal_seq <= illegal_seq | illegal_nxt;
		end
	end

	// Write hold-off after self-refresh exit, fixed in clock cycles.
	always_ff @(posedge core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			wr_cnt_r <= '0;
		else if (srx_event)
			wr_cnt_r <= CW'(`SCKE_WRITE_AFTER_SRX);
		else if (wr_cnt_r != '0)
			wr_cnt_r <= wr_cnt_r - 1'b1;
	end

	// Registered status outputs; the state and power flags track state_r, the others trail it by one cycle.
	always_ff @(posedge core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			power_state <= 3'h0;
			in_power_down <= 1'b0;
			in_self_refresh <= 1'b0;
			cmd_accept <= 1'b0;
			device_idle <= 1'b0;
			read_allowed <= 1'b0;
			write_allowed <= 1'b0;
		end
		else
		begin
			power_state <= state_nxt;
			in_power_down <= (state_nxt == SCKE_PPD) || (state_nxt == SCKE_APD);
			in_self_refresh <= (state_nxt == SCKE_SELF_REF);
			cmd_accept <= !low_power && cke;
			device_idle <= idle_now && (state_r == SCKE_IDLE);
			read_allowed <= xsdll_done && xs_done && !low_power;
			write_allowed <= write_ok && xs_done && !low_power;
		end
	end
endmodule : scke_power_ctrl
`default_nettype wire

/* src/scke_timer.sv */
`include "scke_defines.svh"
`default_nettype none
// Down counter that reports when a loaded delay has run out.
module scke_timer
	import scke_pkg::*;
#(
	parameter int W = 16
)
(
	input wire logic core_clk, // Clock.
	input wire logic rst_n, // Synchronised reset, active low.
	input wire logic load, // Restart the delay.
	input wire logic [W-1:0] count, // Delay in cycles.
	output logic done // Delay has elapsed.
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic done_nxt;

	// Count down to zero; a load takes precedence over the count.
	assign cnt_nxt = load ? count : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
	assign done_nxt = (cnt_nxt == '0);

	// Starts done so nothing waits after reset.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= '0;
			done <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			done <= done_nxt;
		end
	end
endmodule : scke_timer
`default_nettype wire
